// file: irt_pkg.sv
// Package with register map, field layout and constants of the RC trim registers
package irt_pkg;

    localparam int unsigned TRIM_W        = 16;
    localparam int unsigned BYTE_W        = 8;
    localparam int unsigned BUS_W         = 32;
    localparam int unsigned ADDR_W        = 8;

    // Register indices, byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_TRIM_HIGH = 8'h18;
    localparam logic [ADDR_W-1:0] IDX_TRIM_LOW  = 8'h19;
    localparam logic [ADDR_W-1:0] IDX_STATUS    = 8'h20;

    // Field positions inside the sixteen-bit trim value
    localparam int unsigned TC_MSB        = 15;
    localparam int unsigned TC_LSB        = 11;
    localparam int unsigned TC_W          = TC_MSB - TC_LSB + 1;
    localparam int unsigned FREQ_MSB      = 9;
    localparam int unsigned FREQ_LSB      = 0;
    localparam int unsigned FREQ_W        = FREQ_MSB - FREQ_LSB + 1;
    localparam int unsigned COARSE_MSB    = 9;
    localparam int unsigned COARSE_LSB    = 6;
    localparam int unsigned COARSE_W      = COARSE_MSB - COARSE_LSB + 1;
    localparam int unsigned FINE_MSB      = 5;
    localparam int unsigned FINE_LSB      = 0;
    localparam int unsigned FINE_W        = FINE_MSB - FINE_LSB + 1;

    // Implemented bits, bit 10 is reserved and reads as zero
    localparam logic [TRIM_W-1:0] TRIM_IMPL_MASK = 16'hfbff;
    localparam logic [TRIM_W-1:0] TRIM_RESET     = 16'h0000;

    // Status register bit positions
    localparam int unsigned ST_LOAD_DONE  = 0;
    localparam int unsigned ST_GUARD      = 1;
    localparam int unsigned ST_PLL        = 2;

    typedef enum logic [1:0] {
        IRT_LD_RESET = 2'b00,
        IRT_LD_REQ   = 2'b01,
        IRT_LD_WAIT  = 2'b11,
        IRT_LD_DONE  = 2'b10
    } irt_load_state_t;

endpackage

// file: irt_flash_loader.sv
// Fetches the factory trim word from flash once after reset release
`timescale 1ns/1ps
module irt_flash_loader
    import irt_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    output logic                   flash_req,
    input  wire logic              flash_ack,
    input  wire logic [TRIM_W-1:0] flash_data,
    output logic                   load_pulse,
    output logic [TRIM_W-1:0]      load_value,
    output logic                   load_done
);

    irt_load_state_t state;
    irt_load_state_t next_state;

    always_comb begin
        next_state = state;
        case (state)
            IRT_LD_RESET: next_state = IRT_LD_REQ;
            IRT_LD_REQ:   next_state = IRT_LD_WAIT;
            IRT_LD_WAIT:  if (flash_ack) next_state = IRT_LD_DONE;
            IRT_LD_DONE:  next_state = IRT_LD_DONE;
            default:      next_state = IRT_LD_RESET;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= IRT_LD_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Factory value goes out combinationally with the pulse
    always_comb begin
        flash_req  = (state == IRT_LD_REQ) || (state == IRT_LD_WAIT);
        load_pulse = (state == IRT_LD_WAIT) && flash_ack;
        load_value = flash_data & TRIM_IMPL_MASK;
        load_done  = (state == IRT_LD_DONE);
    end

endmodule // irt_flash_loader

// file: irt_tc_decode.sv
// Splits the trim value into oscillator controls and decodes the compensation code
`timescale 1ns/1ps
module irt_tc_decode
    import irt_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic [TRIM_W-1:0]   trim_value,
    output logic [TC_W-1:0]          temp_coeff_trim,
    output logic [FREQ_W-1:0]        rc_freq_trim,
    output logic [COARSE_W-1:0]      freq_coarse,
    output logic [FINE_W-1:0]        freq_fine,
    output logic                     tc_comp_enable,
    output logic                     tc_positive,
    output logic [TC_W-2:0]          tc_magnitude
);

    always_ff @(posedge clk) begin
        if (rst) begin
            temp_coeff_trim <= '0;
            rc_freq_trim    <= '0;
            freq_coarse     <= '0;
            freq_fine       <= '0;
            tc_comp_enable  <= 1'b0;
            tc_positive     <= 1'b0;
            tc_magnitude    <= '0;
        end else begin
            temp_coeff_trim <= trim_value[TC_MSB:TC_LSB];
            rc_freq_trim    <= trim_value[FREQ_MSB:FREQ_LSB];
            freq_coarse     <= trim_value[COARSE_MSB:COARSE_LSB];
            freq_fine       <= trim_value[FINE_MSB:FINE_LSB];
            // Zero magnitude with either sign switches compensation off
            tc_comp_enable  <= (trim_value[TC_MSB-1:TC_LSB] != '0);
            tc_positive     <= trim_value[TC_MSB];
            tc_magnitude    <= trim_value[TC_MSB-1:TC_LSB];
        end
    end

endmodule // irt_tc_decode

// file: irt_trim_regs.sv
// Internal RC oscillator trim registers with Avalon-MM slave
`timescale 1ns/1ps
module irt_trim_regs
    import irt_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst,
    // Avalon-MM slave, byte address
    input  wire logic [ADDR_W+1:0]   avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [BUS_W-1:0]    avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic [BUS_W-1:0]         avs_readdata,
    output logic                     avs_waitrequest,
    // Flash factory value fetch
    output logic                     flash_req,
    input  wire logic                flash_ack,
    input  wire logic [TRIM_W-1:0]   flash_data,
    // Joining signals of the clock unit
    input  wire logic                config_guard,
    input  wire logic                pll_drives_system,
    output logic                     clear_pll_lock,
    output logic                     clear_osc_stable,
    // Oscillator controls
    output logic [TC_W-1:0]          temp_coeff_trim,
    output logic [FREQ_W-1:0]        rc_freq_trim,
    output logic [COARSE_W-1:0]      freq_coarse,
    output logic [FINE_W-1:0]        freq_fine,
    output logic                     tc_comp_enable,
    output logic                     tc_positive,
    output logic [TC_W-2:0]          tc_magnitude
);

    logic [TRIM_W-1:0] trim_value;
    logic              load_pulse;
    logic [TRIM_W-1:0] load_value;
    logic              load_done;
    logic              bus_ack;
    logic              wr_commit;
    logic              rd_commit;
    logic              hit_high;
    logic              hit_low;
    logic              hit_status;
    logic              wr_trim;

    function automatic logic addr_is(input logic [ADDR_W+1:0] addr,
                                     input logic [ADDR_W-1:0] idx);
        addr_is = (addr == {idx, 2'b00});
    endfunction

    irt_flash_loader u_loader (
        .clk        (clk),
        .rst        (rst),
        .flash_req  (flash_req),
        .flash_ack  (flash_ack),
        .flash_data (flash_data),
        .load_pulse (load_pulse),
        .load_value (load_value),
        .load_done  (load_done)
    );

    irt_tc_decode u_decode (
        .clk             (clk),
        .rst             (rst),
        .trim_value      (trim_value),
        .temp_coeff_trim (temp_coeff_trim),
        .rc_freq_trim    (rc_freq_trim),
        .freq_coarse     (freq_coarse),
        .freq_fine       (freq_fine),
        .tc_comp_enable  (tc_comp_enable),
        .tc_positive     (tc_positive),
        .tc_magnitude    (tc_magnitude)
    );

    // Address decode
    always_comb begin
        hit_high   = addr_is(avs_address, IDX_TRIM_HIGH);
        hit_low    = addr_is(avs_address, IDX_TRIM_LOW);
        hit_status = addr_is(avs_address, IDX_STATUS);
    end

    // Bus answers one cycle after the request, held off until load is done
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= (avs_read || avs_write) && !bus_ack && load_done;
        end
    end

    always_comb begin
        avs_waitrequest = (avs_read || avs_write) && !bus_ack;
        wr_commit       = avs_write && bus_ack;
        rd_commit       = avs_read && bus_ack;
        wr_trim         = wr_commit && avs_byteenable[0] && (hit_high || hit_low);
    end

    // Trim storage
    always_ff @(posedge clk) begin
        if (rst) begin
            trim_value <= TRIM_RESET;
        end else if (load_pulse) begin
            trim_value <= load_value;
        end else if (wr_trim && !config_guard) begin
            if (hit_high) begin
                trim_value[TRIM_W-1:BYTE_W] <= avs_writedata[BYTE_W-1:0] &
                                               TRIM_IMPL_MASK[TRIM_W-1:BYTE_W];
            end else begin
                trim_value[BYTE_W-1:0] <= avs_writedata[BYTE_W-1:0] &
                                          TRIM_IMPL_MASK[BYTE_W-1:0];
            end
        end
    end

    // Status clear pulses on any trim write under PLL clocking
    always_ff @(posedge clk) begin
        if (rst) begin
            clear_pll_lock   <= 1'b0;
            clear_osc_stable <= 1'b0;
        end else begin
            clear_pll_lock   <= wr_trim && pll_drives_system;
            clear_osc_stable <= wr_trim && pll_drives_system;
        end
    end

    // Read data, registered with the answer
    always_ff @(posedge clk) begin
        if (rst) begin
            avs_readdata <= '0;
        end else if ((avs_read || avs_write) && !bus_ack && load_done) begin
            avs_readdata <= '0;
            if (avs_read && hit_high) begin
                avs_readdata[BYTE_W-1:0] <= trim_value[TRIM_W-1:BYTE_W];
            end else if (avs_read && hit_low) begin
                avs_readdata[BYTE_W-1:0] <= trim_value[BYTE_W-1:0];
            end else if (avs_read && hit_status) begin
                avs_readdata[ST_LOAD_DONE] <= load_done;
                avs_readdata[ST_GUARD]     <= config_guard;
                avs_readdata[ST_PLL]       <= pll_drives_system;
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_trim_write_pll;
        wr_trim && pll_drives_system;
    endsequence

    sequence s_clear_pulse;
        clear_pll_lock && clear_osc_stable ##1 !clear_pll_lock && !clear_osc_stable;
    endsequence

    property p_load_value;
        $rose(load_done) |-> trim_value == ($past(flash_data) & TRIM_IMPL_MASK);
    endproperty
    a_load_value: assert property (p_load_value)
        else $error("Trim not loaded from flash");

    property p_load_start;
        $fell(rst) |-> ##[0:2] flash_req;
    endproperty
    a_load_start: assert property (p_load_start)
        else $error("Flash fetch not started after reset");

    property p_guard_blocks;
        wr_trim && config_guard && !load_pulse |=> $stable(trim_value);
    endproperty
    a_guard_blocks: assert property (p_guard_blocks)
        else $error("Guarded write changed trim");

    property p_write_high;
        wr_trim && hit_high && !config_guard |=>
            trim_value[TRIM_W-1:BYTE_W] ==
            ($past(avs_writedata[BYTE_W-1:0]) & TRIM_IMPL_MASK[TRIM_W-1:BYTE_W]);
    endproperty
    a_write_high: assert property (p_write_high)
        else $error("Unguarded high write not taken");

    property p_clear_status;
        s_trim_write_pll |=> s_clear_pulse;
    endproperty
    a_clear_status: assert property (p_clear_status)
        else $error("Status clear pulse missing");

    property p_clear_cause;
        clear_pll_lock |-> $past(wr_trim) && $past(pll_drives_system);
    endproperty
    a_clear_cause: assert property (p_clear_cause)
        else $error("Spurious status clear");

    property p_tc_field;
        ##1 temp_coeff_trim == $past(trim_value[TC_MSB:TC_LSB]);
    endproperty
    a_tc_field: assert property (p_tc_field)
        else $error("Coefficient trim field misplaced");

    property p_freq_field;
        ##1 rc_freq_trim == $past(trim_value[FREQ_MSB:FREQ_LSB]);
    endproperty
    a_freq_field: assert property (p_freq_field)
        else $error("Frequency trim field misplaced");

    property p_coarse_fine;
        freq_coarse == rc_freq_trim[FREQ_W-1:FINE_W] && freq_fine == rc_freq_trim[FINE_W-1:0];
    endproperty
    a_coarse_fine: assert property (p_coarse_fine)
        else $error("Coarse or fine split wrong");

    property p_comp_off;
        tc_comp_enable == (temp_coeff_trim[TC_W-2:0] != '0);
    endproperty
    a_comp_off: assert property (p_comp_off)
        else $error("Compensation enable wrong");

    property p_sign_mag;
        tc_positive == temp_coeff_trim[TC_W-1] && tc_magnitude == temp_coeff_trim[TC_W-2:0];
    endproperty
    a_sign_mag: assert property (p_sign_mag)
        else $error("Sign or magnitude wrong");

    property p_read_high;
        rd_commit && hit_high |-> avs_readdata[BYTE_W-1:0] == trim_value[TRIM_W-1:BYTE_W];
    endproperty
    a_read_high: assert property (p_read_high)
        else $error("High trim readback wrong");

    property p_read_low;
        rd_commit && hit_low |-> avs_readdata == {24'h000000, trim_value[BYTE_W-1:0]};
    endproperty
    a_read_low: assert property (p_read_low)
        else $error("Low trim readback wrong");

    property p_answer_time;
        load_done && (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest;
    endproperty
    a_answer_time: assert property (p_answer_time)
        else $error("Bus answer late");

    property p_write_low;
        wr_trim && hit_low && !config_guard |=>
            trim_value[BYTE_W-1:0] ==
            ($past(avs_writedata[BYTE_W-1:0]) & TRIM_IMPL_MASK[BYTE_W-1:0]);
    endproperty
    a_write_low: assert property (p_write_low)
        else $error("Unguarded low write not taken");

    property p_high_keeps_low;
        wr_trim && hit_high |=> $stable(trim_value[BYTE_W-1:0]);
    endproperty
    a_high_keeps_low: assert property (p_high_keeps_low)
        else $error("High write disturbed low byte");

    property p_lane_off;
        wr_commit && !avs_byteenable[0] |=> $stable(trim_value);
    endproperty
    a_lane_off: assert property (p_lane_off)
        else $error("Write with lane off changed trim");

    property p_clear_needs_pll;
        wr_trim && !pll_drives_system |=> !clear_pll_lock && !clear_osc_stable;
    endproperty
    a_clear_needs_pll: assert property (p_clear_needs_pll)
        else $error("Status cleared without PLL clocking");

    property p_flash_hold;
        flash_req && !flash_ack |=> flash_req;
    endproperty
    a_flash_hold: assert property (p_flash_hold)
        else $error("Flash request dropped before answer");

    property p_single_load;
        load_done |-> !load_pulse;
    endproperty
    a_single_load: assert property (p_single_load)
        else $error("Factory word loaded twice");

    property p_stall_before_load;
        !load_done && (avs_read || avs_write) |-> avs_waitrequest;
    endproperty
    a_stall_before_load: assert property (p_stall_before_load)
        else $error("Bus answered before factory load");

    property p_readdata_hold;
        rd_commit |=> $stable(avs_readdata);
    endproperty
    a_readdata_hold: assert property (p_readdata_hold)
        else $error("Read data changed after answer");

    property p_read_status;
        rd_commit && hit_status |->
            avs_readdata[ST_LOAD_DONE] && avs_readdata[ST_GUARD] == $past(config_guard) &&
            avs_readdata[ST_PLL] == $past(pll_drives_system);
    endproperty
    a_read_status: assert property (p_read_status)
        else $error("Status readback wrong");

    property p_read_unmapped;
        rd_commit && !(hit_high || hit_low || hit_status) |-> avs_readdata == '0;
    endproperty
    a_read_unmapped: assert property (p_read_unmapped)
        else $error("Unmapped read not zero");

endmodule // irt_trim_regs

// file: tb_internal_rc_trim_regs.sv
// Self-checking testbench for the RC oscillator trim registers
`timescale 1ns/1ps
module tb_internal_rc_trim_regs;
    import irt_pkg::*;

    logic                clk;
    logic                rst;
    logic [ADDR_W+1:0]   avs_address;
    logic                avs_read;
    logic                avs_write;
    logic [BUS_W-1:0]    avs_writedata;
    logic [3:0]          avs_byteenable;
    logic [BUS_W-1:0]    avs_readdata;
    logic                avs_waitrequest;
    logic                flash_req;
    logic                flash_ack;
    logic [TRIM_W-1:0]   flash_data;
    logic                config_guard;
    logic                pll_drives_system;
    logic                clear_pll_lock;
    logic                clear_osc_stable;
    logic [TC_W-1:0]     temp_coeff_trim;
    logic [FREQ_W-1:0]   rc_freq_trim;
    logic [COARSE_W-1:0] freq_coarse;
    logic [FINE_W-1:0]   freq_fine;
    logic                tc_comp_enable;
    logic                tc_positive;
    logic [TC_W-2:0]     tc_magnitude;
    int                  error_cnt;
    int                  n_compared;
    int                  pulse_cnt;
    int                  cyc;
    logic [BUS_W-1:0]    rdv;

    irt_trim_regs dut_u (
        .clk               (clk),
        .rst               (rst),
        .avs_address       (avs_address),
        .avs_read          (avs_read),
        .avs_write         (avs_write),
        .avs_writedata     (avs_writedata),
        .avs_byteenable    (avs_byteenable),
        .avs_readdata      (avs_readdata),
        .avs_waitrequest   (avs_waitrequest),
        .flash_req         (flash_req),
        .flash_ack         (flash_ack),
        .flash_data        (flash_data),
        .config_guard      (config_guard),
        .pll_drives_system (pll_drives_system),
        .clear_pll_lock    (clear_pll_lock),
        .clear_osc_stable  (clear_osc_stable),
        .temp_coeff_trim   (temp_coeff_trim),
        .rc_freq_trim      (rc_freq_trim),
        .freq_coarse       (freq_coarse),
        .freq_fine         (freq_fine),
        .tc_comp_enable    (tc_comp_enable),
        .tc_positive       (tc_positive),
        .tc_magnitude      (tc_magnitude)
    );

    always #12.5 clk = ~clk;

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Bus cycle: hold request until waitrequest is low at a rising edge
    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d,
                       output logic [31:0] rd);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= {24'h0, d};
        avs_read      <= !wr;
        avs_write     <= wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr8(input logic [9:0] a, input logic [7:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
        repeat (2) @(posedge clk);
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
        logic [31:0] x;
        bus(1'b0, a, 8'h00, x);
        chk(x, {24'h0, e});
    endtask

    task automatic load_flash(input logic [15:0] v);
        @(posedge clk);
        while (flash_req !== 1'b1) @(posedge clk);
        flash_ack  <= 1'b1;
        flash_data <= v;
        @(posedge clk);
        flash_ack  <= 1'b0;
        flash_data <= ~v;
    endtask

    task automatic check_dec(input logic [15:0] v);
        chk(32'(temp_coeff_trim), 32'(v[15:11]));
        chk(32'(rc_freq_trim), 32'(v[9:0]));
        chk(32'(freq_coarse), 32'(v[9:6]));
        chk(32'(freq_fine), 32'(v[5:0]));
        chk(32'(tc_comp_enable), 32'(v[14:11] != 4'h0));
        chk(32'(tc_positive), 32'(v[15]));
        chk(32'(tc_magnitude), 32'(v[14:11]));
    endtask

    // Both clear outputs must pulse together; count the pulses
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (!rst) begin
            if (clear_pll_lock === 1'b1 && clear_osc_stable === 1'b1) pulse_cnt++;
            chk(32'(clear_pll_lock), 32'(clear_osc_stable));
        end
        if (cyc >= 20000) begin
            error_cnt++;
            wrap_up();
        end
    end

    initial begin
        clk = 1'b0; rst = 1'b1; cyc = 0; pulse_cnt = 0;
        error_cnt = 0; n_compared = 0;
        avs_address = '0; avs_read = 1'b0; avs_write = 1'b0;
        avs_writedata = '0; avs_byteenable = 4'h1;
        flash_ack = 1'b0; flash_data = '0;
        config_guard = 1'b0; pll_drives_system = 1'b0;
        repeat (8) @(posedge clk);
        chk(32'(rc_freq_trim), 32'h0);
        rst <= 1'b0;
        // Read stalls until the factory word is in
        fork
            bus(1'b0, 10'h060, 8'h00, rdv);
            load_flash(16'ha5c3);
        join
        chk(rdv, 32'ha1);
        rd_chk(10'h064, 8'hc3);
        rd_chk(10'h080, 8'h01);
        check_dec(16'ha1c3);
        $display("test load done");
        wr8(10'h060, 8'h7f);
        wr8(10'h064, 8'h12);
        rd_chk(10'h060, 8'h7b);
        rd_chk(10'h064, 8'h12);
        check_dec(16'h7b12);
        chk(32'(pulse_cnt), 32'd0);
        $display("test write done");
        config_guard <= 1'b1;
        wr8(10'h060, 8'h00);
        wr8(10'h064, 8'hff);
        rd_chk(10'h060, 8'h7b);
        rd_chk(10'h064, 8'h12);
        rd_chk(10'h080, 8'h03);
        chk(32'(pulse_cnt), 32'd0);
        $display("test guard done");
        pll_drives_system <= 1'b1;
        wr8(10'h064, 8'h55);
        rd_chk(10'h064, 8'h12);
        chk(32'(pulse_cnt), 32'd1);
        config_guard <= 1'b0;
        wr8(10'h064, 8'h55);
        rd_chk(10'h064, 8'h55);
        chk(32'(pulse_cnt), 32'd2);
        avs_byteenable <= 4'h0;
        wr8(10'h064, 8'haa);
        avs_byteenable <= 4'h1;
        rd_chk(10'h064, 8'h55);
        rd_chk(10'h080, 8'h05);
        chk(32'(pulse_cnt), 32'd2);
        pll_drives_system <= 1'b0;
        $display("test pll done");
        for (int i = 0; i < 32; i++) begin
            wr8(10'h060, {i[4:0], 3'b011});
            check_dec({i[4:0], 3'b011, 8'h55});
        end
        $display("test tc codes done");
        wr8(10'h070, 8'hff);
        rd_chk(10'h070, 8'h00);
        wr8(10'h080, 8'h00);
        rd_chk(10'h080, 8'h01);
        rd_chk(10'h060, 8'hfb);
        $display("test unmapped done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        chk(32'(rc_freq_trim), 32'h0);
        rst <= 1'b0;
        load_flash(16'h0432);
        rd_chk(10'h060, 8'h00);
        rd_chk(10'h064, 8'h32);
        check_dec(16'h0032);
        $display("test second reset done");
        wrap_up();
    end
endmodule // tb_internal_rc_trim_regs
